//--- src/instr_decode_map.svh
`ifndef INSTR_DECODE_MAP_SVH
`define INSTR_DECODE_MAP_SVH

// Opcode upper bytes
`define OPC_LOAD_BANK_LIT 8'h01
`define OPC_LOAD_WORK_LIT 8'h0E
`define OPC_MUL_LIT 8'h0D
`define OPC_STORE_WORK_HI7 7'h37
// Field positions
`define OPC_HI_MSB 15
`define OPC_HI_LSB 8
`define ACCESS_BIT 8
// Access bank split and indexed window limit
`define ACCESS_SPLIT 8'h80
`define INDEXED_LIMIT 8'h5F
// Reset values
`define WORK_RESET 8'h00
`define BANK_RESET 4'h0
`define PROD_RESET 16'h0000
// Upper page used for the high half of the access bank
`define ACCESS_HIGH_PAGE 4'hF

`endif

//--- src/instr_decode_pkg.sv
package instr_decode_pkg;
  typedef enum logic [2:0] {
    op_none_t_e = 3'b000,
    op_bank_lit_e = 3'b001,
    op_work_lit_e = 3'b011,
    op_store_e = 3'b010,
    op_mul_e = 3'b110
  } op_kind_t;
endpackage : instr_decode_pkg

//--- src/file_addr_resolve.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_decode_map.svh"

module file_addr_resolve (
  input wire logic [7:0] file_i,
  input wire logic access_sel_i,
  input wire logic ext_en_i,
  input wire logic [3:0] bank_i,
  input wire logic [7:0] index_base_i,
  output logic [11:0] addr_o,
  output logic indexed_o
);
  logic [11:0] index_sum;

  assign index_sum = {4'h0, index_base_i} + {4'h0, file_i};

  always_comb begin
    indexed_o = 1'b0;
    if (access_sel_i) begin
      addr_o = {bank_i, file_i};
    end else if (ext_en_i && (file_i <= `INDEXED_LIMIT)) begin
      addr_o = index_sum;
      indexed_o = 1'b1;
    end else if (file_i < `ACCESS_SPLIT) begin
      addr_o = {4'h0, file_i};
    end else begin
      addr_o = {`ACCESS_HIGH_PAGE, file_i};
    end
  end
endmodule : file_addr_resolve

`default_nettype wire

//--- src/move_multiply_instr_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "instr_decode_map.svh"

module move_multiply_instr_decode #(
  parameter int DATA_W = 8,
  parameter int BANK_W = 4,
  parameter int ADDR_W = 12
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_en_i,
  input wire logic [7:0] index_base_i,
  output logic [7:0] work_o,
  output logic [7:0] bank_select_register_o,
  output logic [7:0] product_high_byte_o,
  output logic [7:0] product_low_byte_o,
  output logic file_we_o,
  output logic [11:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_indexed_o,
  output logic flags_we_o,
  output logic illegal_o
);
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Opcode fields and the file map fix these widths
  if (DATA_W != 8) begin : g_bad_data_w
    $error("DATA_W must be 8");
  end
  if (BANK_W != 4) begin : g_bad_bank_w
    $error("BANK_W must be 4");
  end
  if (ADDR_W != DATA_W + BANK_W) begin : g_bad_addr_w
    $error("ADDR_W must equal DATA_W plus BANK_W");
  end
  if (`OPC_HI_MSB - `OPC_HI_LSB + 1 != DATA_W) begin : g_bad_opc_field
    $error("Opcode field must be DATA_W bits wide");
  end
  if (`ACCESS_BIT != `OPC_HI_LSB) begin : g_bad_access_bit
    $error("Access bit must be the lowest opcode bit");
  end
  // Indexed window must sit inside the low access half
  if (`INDEXED_LIMIT >= `ACCESS_SPLIT) begin : g_bad_window
    $error("Indexed window overlaps the high access half");
  end
  if ($bits(`ACCESS_SPLIT) != DATA_W) begin : g_bad_split_w
    $error("Access split must be DATA_W bits wide");
  end
  // Reset constants must match the register widths
  if ($bits(`WORK_RESET) != DATA_W) begin : g_bad_work_reset
    $error("Working reset value width differs from DATA_W");
  end
  if ($bits(`BANK_RESET) != BANK_W) begin : g_bad_bank_reset
    $error("Bank reset value width differs from BANK_W");
  end
  if ($bits(`PROD_RESET) != 2 * DATA_W) begin : g_bad_prod_reset
    $error("Product reset value width differs from twice DATA_W");
  end
  if ($bits(`ACCESS_HIGH_PAGE) != BANK_W) begin : g_bad_high_page
    $error("Access high page width differs from BANK_W");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Decode
  logic [7:0] opc_hi;
  logic [7:0] lit;
  logic match_bank_lit;
  logic match_work_lit;
  logic match_mul;
  logic match_store;
  instr_decode_pkg::op_kind_t kind;
  logic do_bank_lit;
  logic do_work_lit;
  logic do_mul;
  logic do_store;
  logic access_sel;

  // Architectural registers
  logic [DATA_W-1:0] work_q;
  logic [DATA_W-1:0] work_d;
  logic [BANK_W-1:0] bank_q;
  logic [BANK_W-1:0] bank_d;
  logic [2*DATA_W-1:0] prod_q;
  logic [2*DATA_W-1:0] prod_d;
  logic [2*DATA_W-1:0] partial [DATA_W];
  logic [2*DATA_W-1:0] partial_sum [DATA_W+1];

  // File store path
  logic [ADDR_W-1:0] addr_res;
  logic indexed_res;
  logic file_we_d;
  logic [ADDR_W-1:0] file_addr_d;
  logic [DATA_W-1:0] file_wdata_d;
  logic file_indexed_d;
  logic illegal_d;

  assign opc_hi = instr_i[`OPC_HI_MSB:`OPC_HI_LSB];
  assign lit = instr_i[7:0];
  assign access_sel = instr_i[`ACCESS_BIT];

  // Pattern matches before priority is applied
  assign match_bank_lit = (opc_hi == `OPC_LOAD_BANK_LIT);
  assign match_work_lit = (opc_hi == `OPC_LOAD_WORK_LIT);
  assign match_mul = (opc_hi == `OPC_MUL_LIT);
  assign match_store = (opc_hi[7:1] == `OPC_STORE_WORK_HI7);

  always_comb begin
    kind = instr_decode_pkg::op_none_t_e;
    if (!instr_valid_i) begin
      kind = instr_decode_pkg::op_none_t_e;
    end else if (match_bank_lit) begin
      kind = instr_decode_pkg::op_bank_lit_e;
    end else if (match_work_lit) begin
      kind = instr_decode_pkg::op_work_lit_e;
    end else if (match_mul) begin
      kind = instr_decode_pkg::op_mul_e;
    end else if (match_store) begin
      kind = instr_decode_pkg::op_store_e;
    end
  end

  // ----------------------------------------
  // Per-instruction strobes
  // ----------------------------------------
  assign do_bank_lit = (kind == instr_decode_pkg::op_bank_lit_e);
  assign do_work_lit = (kind == instr_decode_pkg::op_work_lit_e);
  assign do_mul = (kind == instr_decode_pkg::op_mul_e);
  assign do_store = (kind == instr_decode_pkg::op_store_e);
  // Valid word outside the four patterns
  assign illegal_d = instr_valid_i && (kind == instr_decode_pkg::op_none_t_e);

  // ----------------------------------------
  // Working register
  // ----------------------------------------
  // Only the literal load writes; store and multiply read the old value
  always_comb begin
    work_d = work_q;
    if (do_work_lit) begin
      work_d = lit;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      work_q <= `WORK_RESET;
    end else begin
      work_q <= work_d;
    end
    // Multiply never writes here
  end

  // ----------------------------------------
  // Bank select
  // ----------------------------------------
  // Only the low nibble is kept, so upper literal bits drop out
  always_comb begin
    bank_d = bank_q;
    if (do_bank_lit) begin
      bank_d = lit[BANK_W-1:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bank_q <= `BANK_RESET;
    end else begin
      bank_q <= bank_d;
    end
  end

  assign bank_select_register_o = {4'h0, bank_q};

  // ----------------------------------------
  // Product pair
  // ----------------------------------------
  // Shift-and-add rows, one per working register bit, all in one cycle
  assign partial_sum[0] = '0;
  for (genvar g = 0; g < DATA_W; g++) begin : g_mul_row
    assign partial[g] = work_q[g] ? ((2 * DATA_W)'(lit) << g) : '0;
    assign partial_sum[g + 1] = partial_sum[g] + partial[g];
  end

  // Both bytes load together so they always belong to one product
  always_comb begin
    prod_d = prod_q;
    if (do_mul) begin
      prod_d = partial_sum[DATA_W];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prod_q <= `PROD_RESET;
    end else begin
      prod_q <= prod_d;
    end
  end

  assign product_high_byte_o = prod_q[15:8];
  assign product_low_byte_o = prod_q[7:0];

  // ----------------------------------------
  // File store
  // ----------------------------------------
  file_addr_resolve u_resolve (
    .file_i(lit),
    .access_sel_i(access_sel),
    .ext_en_i(ext_en_i),
    .bank_i(bank_q),
    .index_base_i(index_base_i),
    .addr_o(addr_res),
    .indexed_o(indexed_res)
  );

  // Store takes the working value before any same-edge load
  assign file_we_d = do_store;

  always_comb begin
    file_addr_d = file_addr_o;
    if (do_store) begin
      file_addr_d = addr_res;
    end
  end

  always_comb begin
    file_wdata_d = file_wdata_o;
    if (do_store) begin
      file_wdata_d = work_q;
    end
  end

  always_comb begin
    file_indexed_d = file_indexed_o;
    if (do_store) begin
      file_indexed_d = indexed_res;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= file_we_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      file_addr_o <= '0;
    end else begin
      file_addr_o <= file_addr_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      file_wdata_o <= '0;
    end else begin
      file_wdata_o <= file_wdata_d;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      file_indexed_o <= 1'b0;
    end else begin
      file_indexed_o <= file_indexed_d;
    end
  end

  // ----------------------------------------
  // Status and decode outcome
  // ----------------------------------------
  // None of the four instructions touches status
  assign flags_we_o = 1'b0;
  assign work_o = work_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= illegal_d;
    end
  end
endmodule : move_multiply_instr_decode

`default_nettype wire

//--- verif/move_multiply_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module move_multiply_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_en_i,
  input wire logic [7:0] work_o,
  input wire logic [7:0] bank_select_register_o,
  input wire logic [7:0] product_high_byte_o,
  input wire logic [7:0] product_low_byte_o,
  input wire logic file_we_o,
  input wire logic [11:0] file_addr_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic file_indexed_o,
  input wire logic flags_we_o
);
  // ---
  // Opcode seen only while valid
  // ---
  wire [7:0] op = instr_i[15:8] & {8{instr_valid_i}};
  wire [7:0] k = instr_i[7:0];
  wire ix = ext_en_i && k <= 8'h5F;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  bank_load_a: assert property (op == 8'h01 |=> bank_select_register_o == $past(k) % 16)
    else $error("bank");
  bank_upper_a: assert property (bank_select_register_o[7:4] == 4'h0)
    else $error("upper");
  work_load_a: assert property (op == 8'h0E |=> work_o == $past(k))
    else $error("work");
  store_data_a: assert property (op[7:1] == 7'h37 |=> file_we_o && file_wdata_o == $past(work_o))
    else $error("store");
  access_addr_a: assert property (op == 8'h6E && !ix |=> !file_indexed_o
    && file_addr_o == {($past(k[7]) ? 4'hF : 4'h0), $past(k)}) else $error("access");
  banked_addr_a: assert property (op == 8'h6F |=>
    file_addr_o == {$past(bank_select_register_o[3:0]), $past(k)}) else $error("banked");
  indexed_mode_a: assert property (op == 8'h6E && ix |=> file_indexed_o)
    else $error("indexed");
  mul_result_a: assert property (op == 8'h0D |=> $stable(work_o) &&
    {product_high_byte_o, product_low_byte_o} == $past(work_o) * $past(k)) else $error("mul");
  no_flags_a: assert property (flags_we_o == 1'b0)
    else $error("flags");
  cover property (op == 8'h0D);
  cover property (op == 8'h6F);
  cover property (op == 8'h6E && ix);
endmodule : move_multiply_checker
bind move_multiply_instr_decode move_multiply_checker u_chk (.*);
`default_nettype wire

//--- verif/move_multiply_instr_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module move_multiply_instr_decode_test;
  logic clock_i = 0, rst_i = 1, instr_valid_i = 0, ext_en_i = 0, chk = 0, we = 0, ix = 0, il = 0;
  logic [15:0] instr_i = 0, p = 0;
  logic [7:0] index_base_i = 0, w = 0, b = 0, wd = 0;
  logic [11:0] a = 0;
  logic [7:0] ops [6] = '{8'h01, 8'h0E, 8'h0D, 8'h6E, 8'h6F, 8'h6D};
  wire logic [7:0] work_o, bank_select_register_o, product_high_byte_o, product_low_byte_o;
  wire logic [7:0] file_wdata_o;
  wire logic [11:0] file_addr_o;
  wire logic file_we_o, file_indexed_o, flags_we_o, illegal_o;
  wire logic [54:0] seen = {work_o, bank_select_register_o, product_high_byte_o,
    product_low_byte_o, file_we_o, file_addr_o, file_wdata_o, file_indexed_o, illegal_o};
  logic [54:0] q[$];
  int err_count = 0, samples_checked = 0;
  move_multiply_instr_decode u_dut (.*);
  initial forever #50 clock_i = ~clock_i;
  task automatic check(input logic [54:0] s, input logic [54:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, s, e);
    end
  endtask : check
  task automatic complete_run();
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ---
  // Driver with reference model
  // ---
  task automatic issue(input logic [15:0] i, input logic x, input logic [7:0] ib);
    logic [7:0] f;
    f = i[7:0];
    @(posedge clock_i);
    instr_i <= i;
    instr_valid_i <= 1'b1;
    ext_en_i <= x;
    index_base_i <= ib;
    we = 0;
    il = 0;
    case (i[15:8])
      8'h01: b = {4'h0, f[3:0]};
      8'h0E: w = f;
      8'h0D: p = w * f;
      8'h6E, 8'h6F: begin
        we = 1;
        wd = w;
        ix = !i[8] && x && f <= 8'h5F;
        a = i[8] ? {b[3:0], f} : ix ? 12'(ib) + 12'(f) : {f[7] ? 4'hF : 4'h0, f};
      end
      default: il = 1;
    endcase
    q.push_back({w, b, p, we, a, wd, ix, il});
  endtask : issue
  always @(posedge clock_i) begin
    if (chk) begin
      check(seen, q.pop_front());
      check(55'(flags_we_o), 55'h0);
    end
    chk <= instr_valid_i;
  end
  initial begin
    void'($urandom(43));
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    issue(16'h0EE2, 0, 0);
    issue(16'h0DC4, 0, 0);
    issue(16'h01F5, 0, 0);
    issue(16'h6F20, 0, 0);
    issue(16'h6E5F, 1, 8'hF0);
    issue(16'h6E60, 1, 0);
    issue(16'h6E85, 0, 0);
    issue(16'h0200, 0, 0);
    for (int n = 0; n < 300; n++) issue({ops[$urandom % 6], 8'($urandom)}, 1'($urandom), 8'($urandom));
    @(posedge clock_i);
    instr_valid_i <= 0;
    repeat (2) @(posedge clock_i);
    complete_run();
  end
endmodule : move_multiply_instr_decode_test
`default_nettype wire
